// *** rtl/pwm_center_regs.vh ***
// constants for the paired center-aligned pwm block
`ifndef PWM_CENTER_REGS_VH
`define PWM_CENTER_REGS_VH

// channel and pair counts
`define PWM_NUM_CH        6
`define PWM_NUM_PAIR      3
`define PWM_BYTE_W        8
`define PWM_WIDE_W        16

// pairing control bit positions
`define PWM_PAIR01_BIT    0
`define PWM_PAIR23_BIT    1
`define PWM_PAIR45_BIT    2

// channel that carries the shutdown input
`define PWM_SDN_CH        5

// reset values
`define PWM_RST_CNT       8'h00
`define PWM_RST_PER       8'h00
`define PWM_RST_DTY       8'h00
`define PWM_RST_DIR_UP    1'b1
`define PWM_RST_WAVE      1'b1
`define PWM_RST_PIN       1'b0
`define PWM_RST_RUN       1'b0

// 16-bit and 8-bit constants
`define PWM_ZERO16        16'h0000
`define PWM_ONE16         16'h0001
`define PWM_ZERO8         8'h00

`endif

// *** rtl/pwm_step.v ***
// next-state logic of one counter, 8-bit or paired 16-bit
`timescale 1ns/10ps
`default_nettype none
`include "pwm_center_regs.vh"

module pwm_step (
    // timing
    input  wire        tick,
    input  wire        run,
    input  wire        center,
    // compare values and state
    input  wire [15:0] per,
    input  wire [15:0] dty,
    input  wire [15:0] cnt,
    input  wire        dirUp,
    input  wire        wave,
    // next state
    output reg  [15:0] nxtCnt,
    output reg         nxtDirUp,
    output reg         nxtWave,
    output reg         reload
);

    wire [15:0] incCnt = cnt + `PWM_ONE16;
    wire [15:0] decCnt = cnt - `PWM_ONE16;
    wire [15:0] perM1  = per - `PWM_ONE16;

    always @* begin
        nxtCnt   = cnt;
        nxtDirUp = dirUp;
        nxtWave  = wave;
        reload   = 1'b0;
        if (tick && run) begin
            if (per == `PWM_ZERO16) begin
                nxtCnt   = `PWM_ZERO16;
                nxtDirUp = 1'b1;
            end else if (!center) begin
                if (cnt >= perM1) begin
                    nxtCnt  = `PWM_ZERO16;
                    nxtWave = 1'b1;
                    reload  = 1'b1;
                end else begin
                    nxtCnt = incCnt;
                    if (incCnt == dty)
                        nxtWave = ~wave;
                end
            end else if (dirUp || cnt == `PWM_ZERO16) begin
                nxtDirUp = 1'b1;
                if (cnt >= per) begin
                    nxtCnt   = decCnt;
                    nxtDirUp = 1'b0;
                    if (decCnt == dty)
                        nxtWave = ~wave;
                    // period of one turns straight onto zero
                    if (decCnt == `PWM_ZERO16) begin
                        nxtDirUp = 1'b1;
                        nxtWave  = 1'b1;
                        reload   = 1'b1;
                    end
                end else begin
                    nxtCnt = incCnt;
                    if (incCnt == dty)
                        nxtWave = ~wave;
                end
            end else begin
                nxtCnt = decCnt;
                if (decCnt == dty)
                    nxtWave = ~wave;
                if (decCnt == `PWM_ZERO16) begin
                    nxtDirUp = 1'b1;
                    nxtWave  = 1'b1;
                    reload   = 1'b1;
                end
            end
        end
    end

endmodule // pwm_step
`default_nettype wire

// *** rtl/pwm_shutdown_flag.v ***
// emergency shutdown interrupt flag and request
`timescale 1ns/10ps
`default_nettype none
`include "pwm_center_regs.vh"

module pwm_shutdown_flag (
    // clock and reset
    input  wire core_clk,
    input  wire sys_rst,
    // controls
    input  wire shutdownInputEnable,
    input  wire shutdownModeEnable,
    input  wire shutdownActiveLevel,
    input  wire shutdownIrqEnable,
    input  wire shutdownFlagClear,
    // channel 5 pin level
    input  wire sdnPinLevel,
    // status
    output reg  shutdownIrqFlag,
    output reg  shutdownIrq
);

    reg  pinPrev_ff;
    reg  modePrev_ff;
    wire pinChange = shutdownInputEnable & (pinPrev_ff ^ sdnPinLevel);
    wire modeRise  = shutdownModeEnable & ~modePrev_ff &
                     (sdnPinLevel == shutdownActiveLevel);
    wire setEvt    = pinChange | modeRise;

    always @(posedge core_clk) begin
        if (sys_rst) begin
            // primed with the live pin: no false edge on release
            pinPrev_ff      <= sdnPinLevel;
            modePrev_ff     <= 1'b0;
            shutdownIrqFlag <= 1'b0;
            shutdownIrq     <= 1'b0;
        end else begin
            pinPrev_ff  <= sdnPinLevel;
            modePrev_ff <= shutdownModeEnable;
            if (setEvt)
                shutdownIrqFlag <= 1'b1;
            else if (shutdownFlagClear)
                shutdownIrqFlag <= 1'b0;
            shutdownIrq <= shutdownIrqEnable &
                           (shutdownIrqFlag | setEvt) &
                           ~(shutdownFlagClear & ~setEvt);
        end
    end

endmodule // pwm_shutdown_flag
`default_nettype wire

// *** rtl/pwm_center_align_concat.v ***
// six-channel pwm with center alignment and 16-bit pairing
`timescale 1ns/10ps
`default_nettype none
`include "pwm_center_regs.vh"

module pwm_center_align_concat (
    // clock and reset
    input  wire        core_clk,
    input  wire        sys_rst,
    // prescaled clock ticks, one-cycle pulses
    input  wire        tickSrcA,
    input  wire        tickSrcB,
    // per-channel controls, bit n is channel n
    input  wire [5:0]  channel_enable,
    input  wire [5:0]  channel_polarity,
    input  wire [5:0]  channel_clock_sel,
    input  wire [5:0]  center_align_sel,
    // pairing control
    input  wire        pair_ch0_ch1,
    input  wire        pair_ch2_ch3,
    input  wire        pair_ch4_ch5,
    // register writes
    input  wire [7:0]  wrData,
    input  wire [5:0]  periodWr,
    input  wire [5:0]  dutyWr,
    input  wire [5:0]  counterWr,
    // shutdown controls
    input  wire        shutdown_input_enable,
    input  wire        shutdown_mode_enable,
    input  wire        shutdownActiveLevel,
    input  wire        shutdown_irq_enable,
    input  wire        shutdownFlagClear,
    input  wire        sdnPinLevel,
    // outputs
    output wire [5:0]  channel_output_pin,
    output wire [47:0] channel_counter,
    output wire [5:0]  channelDirUp,
    output wire        shutdown_irq_flag,
    output wire        shutdownIrq
);

    // channel state
    reg  [7:0] cnt_ff    [0:5];
    reg  [7:0] perAct_ff [0:5];
    reg  [7:0] dtyAct_ff [0:5];
    reg  [7:0] perBuf_ff [0:5];
    reg  [7:0] dtyBuf_ff [0:5];
    reg  [5:0] dirUp_ff;
    reg  [5:0] wave_ff;
    reg  [5:0] pin_ff;
    reg  [5:0] run_ff;
    wire [2:0] pairCtl;

    assign pairCtl[`PWM_PAIR01_BIT] = pair_ch0_ch1;
    assign pairCtl[`PWM_PAIR23_BIT] = pair_ch2_ch3;
    assign pairCtl[`PWM_PAIR45_BIT] = pair_ch4_ch5;

    assign channel_output_pin = pin_ff;
    assign channelDirUp       = dirUp_ff;

    // level from polarity and wave; boundary cases
    function pinLevel;
        input        pol;
        input [15:0] per;
        input [15:0] dty;
        input        wave;
        begin
            if (per == `PWM_ZERO16)
                pinLevel = pol;
            else if (dty == `PWM_ZERO16)
                pinLevel = ~pol;
            else if (dty >= per)
                pinLevel = pol;
            else
                pinLevel = pol ? wave : ~wave;
        end
    endfunction

    genvar p;
    generate
        for (p = 0; p < `PWM_NUM_PAIR; p = p + 1) begin : g_pair
            localparam HI = 2 * p;
            localparam LO = 2 * p + 1;

            wire paired = pairCtl[p];

            // both bytes leave the same flops at once
            assign channel_counter[8*HI +: 8] = cnt_ff[HI];
            assign channel_counter[8*LO +: 8] = cnt_ff[LO];

            wire runLo  = run_ff[LO];
            wire runHi  = run_ff[HI] & ~paired;
            wire liveHi = paired ? run_ff[LO] : run_ff[HI];

            wire tickLo = channel_clock_sel[LO] ? tickSrcB : tickSrcA;
            wire tickHi = channel_clock_sel[HI] ? tickSrcB : tickSrcA;

            // lower-numbered channel gives high bytes; wide view
            wire [7:0]  hiCnt = paired ? cnt_ff[HI] : `PWM_ZERO8;
            wire [7:0]  hiPer = paired ? perAct_ff[HI] : `PWM_ZERO8;
            wire [7:0]  hiDty = paired ? dtyAct_ff[HI] : `PWM_ZERO8;
            wire [15:0] cntLo = {hiCnt, cnt_ff[LO]};
            wire [15:0] perLo = {hiPer, perAct_ff[LO]};
            wire [15:0] dtyLo = {hiDty, dtyAct_ff[LO]};
            wire [15:0] cntHi = {`PWM_ZERO8, cnt_ff[HI]};
            wire [15:0] perHi = {`PWM_ZERO8, perAct_ff[HI]};
            wire [15:0] dtyHi = {`PWM_ZERO8, dtyAct_ff[HI]};

            wire [15:0] nxtCntLo;
            wire [15:0] nxtCntHi;
            wire        nxtDirLo;
            wire        nxtDirHi;
            wire        nxtWaveLo;
            wire        nxtWaveHi;
            wire        reloadLo;
            wire        reloadHi;

            // low-order alignment bit selects the mode
            pwm_step u_step_lo (
                .tick     (tickLo),
                .run      (runLo),
                .center   (center_align_sel[LO]),
                .per      (perLo),
                .dty      (dtyLo),
                .cnt      (cntLo),
                .dirUp    (dirUp_ff[LO]),
                .wave     (wave_ff[LO]),
                .nxtCnt   (nxtCntLo),
                .nxtDirUp (nxtDirLo),
                .nxtWave  (nxtWaveLo),
                .reload   (reloadLo)
            );

            pwm_step u_step_hi (
                .tick     (tickHi),
                .run      (runHi),
                .center   (center_align_sel[HI]),
                .per      (perHi),
                .dty      (dtyHi),
                .cnt      (cntHi),
                .dirUp    (dirUp_ff[HI]),
                .wave     (wave_ff[HI]),
                .nxtCnt   (nxtCntHi),
                .nxtDirUp (nxtDirHi),
                .nxtWave  (nxtWaveHi),
                .reload   (reloadHi)
            );

            // a write to either byte clears the pair
            wire clrLo = counterWr[LO] | (paired & counterWr[HI]);
            wire clrHi = counterWr[HI] & ~paired;

            always @(posedge core_clk) begin
                if (sys_rst) begin
                    // up out of reset; all stopped
                    cnt_ff[LO]    <= `PWM_RST_CNT;
                    cnt_ff[HI]    <= `PWM_RST_CNT;
                    perAct_ff[LO] <= `PWM_RST_PER;
                    perAct_ff[HI] <= `PWM_RST_PER;
                    dtyAct_ff[LO] <= `PWM_RST_DTY;
                    dtyAct_ff[HI] <= `PWM_RST_DTY;
                    perBuf_ff[LO] <= `PWM_RST_PER;
                    perBuf_ff[HI] <= `PWM_RST_PER;
                    dtyBuf_ff[LO] <= `PWM_RST_DTY;
                    dtyBuf_ff[HI] <= `PWM_RST_DTY;
                    dirUp_ff[LO]  <= `PWM_RST_DIR_UP;
                    dirUp_ff[HI]  <= `PWM_RST_DIR_UP;
                    wave_ff[LO]   <= `PWM_RST_WAVE;
                    wave_ff[HI]   <= `PWM_RST_WAVE;
                    pin_ff[LO]    <= `PWM_RST_PIN;
                    pin_ff[HI]    <= `PWM_RST_PIN;
                    run_ff[LO]    <= `PWM_RST_RUN;
                    run_ff[HI]    <= `PWM_RST_RUN;
                end else begin
                    // enable takes effect one cycle later, on a clean edge
                    run_ff[LO] <= channel_enable[LO];
                    run_ff[HI] <= channel_enable[HI];

                    // low-order engine, whole pair when joined
                    if (clrLo) begin
                        cnt_ff[LO]    <= `PWM_ZERO8;
                        dirUp_ff[LO]  <= 1'b1;
                        wave_ff[LO]   <= 1'b1;
                        perAct_ff[LO] <= perBuf_ff[LO];
                        dtyAct_ff[LO] <= dtyBuf_ff[LO];
                        if (paired) begin
                            cnt_ff[HI]    <= `PWM_ZERO8;
                            perAct_ff[HI] <= perBuf_ff[HI];
                            dtyAct_ff[HI] <= dtyBuf_ff[HI];
                        end
                    end else begin
                        cnt_ff[LO]   <= nxtCntLo[7:0];
                        dirUp_ff[LO] <= nxtDirLo;
                        wave_ff[LO]  <= nxtWaveLo;
                        if (paired)
                            cnt_ff[HI] <= nxtCntLo[15:8];
                        // reload at end of the effective period
                        if (reloadLo) begin
                            perAct_ff[LO] <= perBuf_ff[LO];
                            dtyAct_ff[LO] <= dtyBuf_ff[LO];
                            if (paired) begin
                                perAct_ff[HI] <= perBuf_ff[HI];
                                dtyAct_ff[HI] <= dtyBuf_ff[HI];
                            end
                        end
                    end

                    // high-order engine, only while unpaired
                    if (clrHi) begin
                        cnt_ff[HI]    <= `PWM_ZERO8;
                        dirUp_ff[HI]  <= 1'b1;
                        wave_ff[HI]   <= 1'b1;
                        perAct_ff[HI] <= perBuf_ff[HI];
                        dtyAct_ff[HI] <= dtyBuf_ff[HI];
                    end else if (!paired) begin
                        cnt_ff[HI]   <= nxtCntHi[7:0];
                        dirUp_ff[HI] <= nxtDirHi;
                        wave_ff[HI]  <= nxtWaveHi;
                        if (reloadHi) begin
                            perAct_ff[HI] <= perBuf_ff[HI];
                            dtyAct_ff[HI] <= dtyBuf_ff[HI];
                        end
                    end else begin
                        // parked while paired, so unpairing resumes upward
                        dirUp_ff[HI] <= `PWM_RST_DIR_UP;
                        wave_ff[HI]  <= `PWM_RST_WAVE;
                    end

                    // buffered writes; last so a stopped channel
                    // sees the new value at once
                    if (periodWr[LO]) begin
                        perBuf_ff[LO] <= wrData;
                        if (!run_ff[LO])
                            perAct_ff[LO] <= wrData;
                    end
                    if (dutyWr[LO]) begin
                        dtyBuf_ff[LO] <= wrData;
                        if (!run_ff[LO])
                            dtyAct_ff[LO] <= wrData;
                    end
                    if (periodWr[HI]) begin
                        perBuf_ff[HI] <= wrData;
                        if (!liveHi)
                            perAct_ff[HI] <= wrData;
                    end
                    if (dutyWr[HI]) begin
                        dtyBuf_ff[HI] <= wrData;
                        if (!liveHi)
                            dtyAct_ff[HI] <= wrData;
                    end

                    // pair drives the low-order pin with its polarity
                    if (runLo)
                        pin_ff[LO] <= pinLevel(channel_polarity[LO],
                                               perLo, dtyLo, wave_ff[LO]);
                    else
                        pin_ff[LO] <= `PWM_RST_PIN;
                    // high-order output held off while paired
                    if (runHi)
                        pin_ff[HI] <= pinLevel(channel_polarity[HI],
                                               perHi, dtyHi, wave_ff[HI]);
                    else
                        pin_ff[HI] <= `PWM_RST_PIN;
                end
            end
        end
    endgenerate

    pwm_shutdown_flag u_shutdown (
        .core_clk            (core_clk),
        .sys_rst             (sys_rst),
        .shutdownInputEnable (shutdown_input_enable),
        .shutdownModeEnable  (shutdown_mode_enable),
        .shutdownActiveLevel (shutdownActiveLevel),
        .shutdownIrqEnable   (shutdown_irq_enable),
        .shutdownFlagClear   (shutdownFlagClear),
        .sdnPinLevel         (sdnPinLevel),
        .shutdownIrqFlag     (shutdown_irq_flag),
        .shutdownIrq         (shutdownIrq)
    );

endmodule // pwm_center_align_concat
`default_nettype wire

// *** bench/pwm_center_align_concat_asserts.sv ***
// port-level assertions for the paired center-aligned pwm
`timescale 1ns/10ps
`default_nettype none
module pwm_center_align_concat_asserts (
    // clock and reset
    input wire        core_clk,
    input wire        sys_rst,
    // controls
    input wire [5:0]  channel_enable,
    input wire [5:0]  counterWr,
    input wire        pair_ch0_ch1,
    input wire        pair_ch2_ch3,
    input wire        shutdown_input_enable,
    input wire        shutdown_mode_enable,
    input wire        shutdown_irq_enable,
    input wire        shutdownFlagClear,
    input wire        sdnPinLevel,
    // outputs
    input wire [5:0]  channel_output_pin,
    input wire [47:0] channel_counter,
    input wire [5:0]  channelDirUp,
    input wire        shutdown_irq_flag,
    input wire        shutdownIrq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    a_irq_needs_flag: assert property (shutdownIrq |-> shutdown_irq_flag)
        else $error("request without flag");
    a_irq_gated_off: assert property ($past(!shutdown_irq_enable)
        |-> !shutdownIrq) else $error("request while disabled");
    a_flag_pin_change: assert property (shutdown_input_enable &&
        !$past(sys_rst) && sdnPinLevel != $past(sdnPinLevel)
        |=> shutdown_irq_flag) else $error("pin change missed");
    a_flag_clear_ok: assert property (shutdownFlagClear &&
        !shutdown_input_enable && !shutdown_mode_enable
        |=> !shutdown_irq_flag) else $error("flag not cleared");
    a_cnt8_clear: assert property (counterWr[0] && !pair_ch0_ch1
        |=> channel_counter[7:0] == 8'h00 && channelDirUp[0])
        else $error("counter write not clearing");
    a_cnt16_clear: assert property (counterWr[0] && pair_ch0_ch1
        |=> channel_counter[15:0] == 16'h0000)
        else $error("paired counter not cleared");
    a_up_at_zero: assert property (!pair_ch0_ch1 &&
        channel_counter[7:0] == 8'h00 |-> channelDirUp[0])
        else $error("direction not up at zero");
    a_high_pin_off: assert property (pair_ch0_ch1 &&
        $past(pair_ch0_ch1) |-> !channel_output_pin[0])
        else $error("high-order pin driven");
    a_stop_disabled: assert property (!pair_ch2_ch3 && !counterWr[2] &&
        !channel_enable[2] && $past(!channel_enable[2])
        |=> $stable(channel_counter[23:16])) else $error("stopped counter moved");
    a_step_by_one: assert property (!pair_ch0_ch1 &&
        !$past(pair_ch0_ch1) && !$past(sys_rst) && !$past(counterWr[0]) &&
        $changed(channel_counter[7:0]) |-> channel_counter[7:0] == 8'h00 ||
        channel_counter[7:0] == $past(channel_counter[7:0]) + 8'h01 ||
        channel_counter[7:0] == $past(channel_counter[7:0]) - 8'h01)
        else $error("counter jumped");
    a_pair_step: assert property (pair_ch0_ch1 && $past(pair_ch0_ch1) &&
        !$past(counterWr[0]) && !$past(counterWr[1]) &&
        $changed(channel_counter[15:0]) |->
        {channel_counter[7:0], channel_counter[15:8]} == 16'h0000 ||
        {channel_counter[7:0], channel_counter[15:8]} ==
        {$past(channel_counter[7:0]), $past(channel_counter[15:8])} + 16'h0001 ||
        {channel_counter[7:0], channel_counter[15:8]} ==
        {$past(channel_counter[7:0]), $past(channel_counter[15:8])} - 16'h0001)
        else $error("paired counter jumped");
endmodule // pwm_center_align_concat_asserts
`default_nettype wire

// *** bench/pwm_pin_load.sv ***
// load circuit on the pwm pins, counting high cycles of one pin
`timescale 1ns/10ps
`default_nettype none
module pwm_pin_load (
    // clock and control
    input  wire logic        core_clk,
    input  wire logic        countClr,
    input  wire logic [2:0]  pinSel,
    // pins
    input  wire logic [5:0]  channel_output_pin,
    // result
    output logic      [15:0] highCount
);
    // an unknown pin level is never counted as high
    always @(posedge core_clk) begin
        if (countClr)
            highCount <= 16'h0000;
        else if (channel_output_pin[pinSel] === 1'b1)
            highCount <= highCount + 16'h0001;
    end
endmodule // pwm_pin_load
`default_nettype wire

// *** bench/pwm_center_align_concat_tb.sv ***
// self-checking bench for the paired center-aligned pwm
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin total_checks = total_checks + 1; \
    if ((g) !== (e)) begin errors = errors + 1; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
module pwm_center_align_concat_tb;
    logic core_clk, sys_rst, tickSrcA, tickSrcB, countClr;
    logic [5:0] channel_enable, channel_polarity, channel_clock_sel;
    logic [5:0] center_align_sel, periodWr, dutyWr, counterWr;
    logic pair_ch0_ch1, pair_ch2_ch3, pair_ch4_ch5, sdnPinLevel;
    logic shutdown_input_enable, shutdown_mode_enable, shutdownActiveLevel;
    logic shutdown_irq_enable, shutdownFlagClear, shutdown_irq_flag;
    logic [7:0]  wrData;
    logic [2:0]  pinSel;
    logic [5:0]  channel_output_pin, channelDirUp;
    logic [47:0] channel_counter;
    logic [15:0] highCount, cnt16, cmax;
    logic        shutdownIrq;
    integer      errors, total_checks, zeros, i, pol;
    logic [7:0]  bPer [6] = '{8'h00, 8'h00, 8'h05, 8'h05, 8'h05, 8'h05};
    logic [7:0]  bDty [6] = '{8'h05, 8'h05, 8'h00, 8'h00, 8'h05, 8'h07};
    logic [5:0]  bPol = 6'h15;
    logic [5:0]  bOut = 6'h19;
    // pair view is {high byte ch0, low byte ch1}
    assign cnt16 = pair_ch0_ch1 ? {channel_counter[7:0], channel_counter[15:8]}
                                : {8'h00, channel_counter[7:0]};
    pwm_center_align_concat DUT (.*);
    pwm_pin_load u_load (.core_clk(core_clk), .countClr(countClr),
        .pinSel(pinSel), .channel_output_pin(channel_output_pin),
        .highCount(highCount));
    always #20 core_clk = ~core_clk;
    task step(input integer n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task finish_test;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task wr(input [5:0] p, input [5:0] d, input [5:0] c, input [7:0] v);
        periodWr = p;
        dutyWr = d;
        counterWr = c;
        wrData = v;
        // strobes drop on the taking edge, so back-to-back writes stay clean
        @(posedge core_clk);
        {periodWr, dutyWr, counterWr} <= 18'h00000;
        #1;
    endtask
    task window(input [2:0] s, input integer n);
        pinSel = s;
        countClr = 1'b1;
        step(1);
        countClr = 1'b0;
        cmax = 16'h0000;
        zeros = 0;
        for (i = 0; i < n; i = i + 1) begin
            step(1);
            if (cnt16 > cmax) cmax = cnt16;
            if (cnt16 == 16'h0000) zeros = zeros + 1;
        end
    endtask
    task setup0(input [7:0] per, input [7:0] dty, input p, input ctr);
        channel_enable = 6'h00;
        step(2);
        // alignment chosen while the channel is stopped
        channel_polarity[0] = p;
        center_align_sel[0] = ctr;
        wr(6'h01, 6'h00, 6'h00, per);
        wr(6'h00, 6'h01, 6'h00, dty);
        wr(6'h00, 6'h00, 6'h01, 8'h5a);
        `CHK(channel_counter[7:0], 8'h00)
        channel_enable = 6'h01;
        step(4);
    endtask
    task wait_flag(input exp);
        i = 0;
        while (shutdown_irq_flag !== 1'b1 && i < 8) begin
            step(1);
            i = i + 1;
        end
        `CHK(shutdown_irq_flag, 1'b1)
        `CHK(shutdownIrq, exp)
        if (shutdown_irq_flag !== 1'b1) finish_test;
    endtask
    task test_reset;
        `CHK(channel_counter, 48'h0)
        `CHK(channelDirUp, 6'h3f)
        `CHK({channel_output_pin, shutdown_irq_flag}, 7'h00)
        step(5);
        `CHK(channel_counter, 48'h0)
    endtask
    task test_center;
        for (pol = 0; pol < 2; pol = pol + 1) begin
            setup0(8'h04, 8'h01, pol[0], 1'b1);
            window(3'h0, 16);
            `CHK(highCount, pol ? 16'h0004 : 16'h000c)
            `CHK(cmax, 16'h0004)
            `CHK(zeros, 2)
        end
        // reload from the buffer at the bottom of the cycle
        wr(6'h01, 6'h00, 6'h00, 8'h02);
        step(10);
        window(3'h0, 16);
        `CHK(cmax, 16'h0002)
        `CHK(zeros, 4)
        // period of one must still reload at its turn onto zero
        wr(6'h01, 6'h00, 6'h00, 8'h01);
        step(6);
        wr(6'h01, 6'h00, 6'h00, 8'h03);
        step(6);
        window(3'h0, 12);
        `CHK(cmax, 16'h0003)
    endtask
    task test_bounds;
        for (pol = 0; pol < 6; pol = pol + 1) begin
            setup0(bPer[pol], bDty[pol], bPol[pol], pol[0]);
            window(3'h0, 8);
            `CHK(highCount, bOut[pol] ? 16'h0008 : 16'h0000)
            if (bPer[pol] == 8'h00) `CHK(cmax, 16'h0000)
        end
        channel_enable = 6'h00;
        step(2);
    endtask
    task test_pair;
        // pairing changed only with both channels stopped
        pair_ch0_ch1 = 1'b1;
        {tickSrcA, tickSrcB} = 2'b01;
        channel_clock_sel = 6'h02;
        channel_polarity = 6'h02;
        center_align_sel = 6'h01;
        wr(6'h01, 6'h00, 6'h00, 8'h01);
        wr(6'h02, 6'h00, 6'h00, 8'h02);
        wr(6'h00, 6'h01, 6'h00, 8'h00);
        wr(6'h00, 6'h02, 6'h02, 8'h80);
        channel_enable = 6'h03;
        step(4);
        window(3'h1, 258);
        `CHK(highCount, 16'h0080)
        `CHK(cmax, 16'h0101)
        if (cnt16 === 16'h0000) step(1);
        wr(6'h00, 6'h00, 6'h01, 8'hff);
        `CHK(cnt16, 16'h0000)
        channel_enable = 6'h00;
        step(2);
        pair_ch0_ch1 = 1'b0;
        {tickSrcA, tickSrcB} = 2'b10;
    endtask
    task test_shutdown;
        shutdown_irq_enable = 1'b1;
        shutdown_input_enable = 1'b1;
        step(2);
        sdnPinLevel = 1'b1;
        wait_flag(1'b1);
        shutdown_input_enable = 1'b0;
        shutdownFlagClear = 1'b1;
        step(1);
        shutdownFlagClear = 1'b0;
        `CHK({shutdown_irq_flag, shutdownIrq}, 2'b00)
        shutdown_irq_enable = 1'b0;
        step(1);
        shutdown_mode_enable = 1'b1;
        wait_flag(1'b0);
    endtask
    initial begin
        {core_clk, tickSrcB, countClr, pinSel, wrData} = 0;
        {channel_enable, channel_polarity, channel_clock_sel} = 0;
        {center_align_sel, periodWr, dutyWr, counterWr} = 0;
        {pair_ch0_ch1, pair_ch2_ch3, pair_ch4_ch5, sdnPinLevel} = 0;
        {shutdown_input_enable, shutdown_mode_enable, shutdownFlagClear} = 0;
        shutdown_irq_enable = 1'b0;
        shutdownActiveLevel = 1'b1;
        tickSrcA = 1'b1;
        errors = 0;
        total_checks = 0;
        sys_rst = 1'b1;
        step(12);
        sys_rst = 1'b0;
        step(1);
        test_reset;
        test_center;
        test_bounds;
        test_pair;
        test_shutdown;
        finish_test;
    end
endmodule // pwm_center_align_concat_tb
bind pwm_center_align_concat pwm_center_align_concat_asserts u_chk (.*);
`default_nettype wire
